//--- verilog/rcs_regs.sv
`timescale 1ns/10ps
`include "rcs_defs.svh"
// Overview of operation
// [RULE1] Status read returns flags, then clears them
// [RULE2] Power-on sets power flag, clears others
// [RULE3] Pin reset sets pin flag
// [RULE4] Watchdog reset sets watchdog flag
// [RULE5] Illegal opcode reset sets its flag
// [RULE6] Illegal fetch address flag: opcode fetches only
// [RULE7] Forced monitor entry reset sets its flag
// [RULE8] Low-voltage reset sets its flag
// [RULE9] Break-clear enable bit gates clearing in break
// [RULE10] Break-state status read clears only if enabled
module rcs_regs (
    input wire logic sys_clk, // 100 MHz system clock
    input wire logic reset_n, // Power-on reset, async, active low
    input wire rcs_pkg::rcs_addr_t avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire rcs_pkg::rcs_word_t avs_writedata, // Write data
    output rcs_pkg::rcs_word_t avs_readdata, // Read data
    output logic avs_waitrequest, // Low for one cycle to answer
    input wire rcs_pkg::rcs_src_t cause_src, // Async reset-source pulses
    input wire logic fetch_src, // Access was an opcode fetch
    input wire logic break_src, // Processor is in break state
    output logic irq // Level interrupt
);
    import rcs_pkg::*;

    // ------------------------------------------------------------
    // Reset release and input synchronisers
    // ------------------------------------------------------------
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    logic [7:0] async_in;
    logic [7:0] in_meta;
    logic [7:0] in_sync;
    logic [7:0] in_prev;
    assign async_in = {break_src, fetch_src, cause_src};
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_meta <= 8'h00;
            in_sync <= 8'h00;
            in_prev <= 8'h00;
        end else begin
            in_meta <= async_in;
            in_sync <= in_meta;
            in_prev <= in_sync;
        end
    end

    // Sources are pulses; only the rising edge counts, so a long pulse
    // does not keep re-setting a flag software has already read.
    logic [5:0] src_evt;
    logic [5:0] src_ok;
    logic in_break;
    logic [7:0] set_vec;
    assign src_evt = in_sync[5:0] & ~in_prev[5:0];
    assign src_ok = {src_evt[5:3], src_evt[2] & in_sync[6], src_evt[1:0]}; // [RULE6]
    assign in_break = in_sync[7];
    assign set_vec = {1'b0, src_ok, 1'b0}; // [RULE3] [RULE4] [RULE5] [RULE7] [RULE8]

    // ------------------------------------------------------------
    // Avalon-MM slave: one wait cycle on every access
    // ------------------------------------------------------------
    rcs_bus_state_t state;
    rcs_bus_state_t next_state;
    logic next_waitrequest;
    rcs_word_t next_readdata;
    logic req;
    logic done;
    rcs_byte_t cause_status;
    rcs_byte_t next_cause_status;
    logic break_clear_enable;
    logic next_break_clear_enable;
    // Reset image of the break control register; only its enable bit is stored
    localparam rcs_byte_t break_ctl_init = `RCS_BRKCTL_RESET;
    rcs_byte_t irq_status;
    rcs_byte_t next_irq_status;
    rcs_byte_t irq_mask;
    rcs_byte_t next_irq_mask;
    logic next_irq;
    logic clr_ok;
    logic rd_cause_clr;
    logic irq_w1c;

    assign req = avs_read | avs_write;
    assign done = req & (state == BUS_ACK);
    assign clr_ok = ~in_break | break_clear_enable; // [RULE9]
    assign rd_cause_clr = done & avs_read & (avs_address == `RCS_ADDR_CAUSE) & clr_ok; // [RULE10]
    assign irq_w1c = done & avs_write & (avs_address == `RCS_ADDR_IRQ_STATUS) & clr_ok;

    always_comb begin
        next_state = state;
        next_readdata = avs_readdata;
        case (state)
            BUS_IDLE: begin
                if (req) begin
                    next_state = BUS_ACK;
                end
                // Data is captured at the take edge so it stands through the answer
                if (avs_read) begin
                    case (avs_address)
                        `RCS_ADDR_CAUSE: next_readdata = {24'h000000, cause_status};
                        `RCS_ADDR_BRKCTL: next_readdata = {24'h000000, break_clear_enable, 7'h00};
                        `RCS_ADDR_IRQ_STATUS: next_readdata = {24'h000000, irq_status};
                        `RCS_ADDR_IRQ_MASK: next_readdata = {24'h000000, irq_mask};
                        default: next_readdata = 32'h00000000;
                    endcase
                end
            end
            BUS_ACK: begin
                // Exactly one answer cycle; the master releases at its end
                next_state = BUS_IDLE;
            end
            default: begin
                next_state = BUS_IDLE;
            end
        endcase
        next_waitrequest = (next_state != BUS_ACK);
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else begin
            state <= next_state;
            avs_waitrequest <= next_waitrequest;
            avs_readdata <= next_readdata;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Only the bits actually returned are cleared, so an event landing
    // during the wait cycle survives the read; set always beats clear.
    always_comb begin
        next_cause_status = cause_status;
        if (rd_cause_clr) begin
            next_cause_status = cause_status & ~avs_readdata[7:0]; // [RULE1] [RULE10]
        end
        next_cause_status = next_cause_status | set_vec;
        next_irq_status = irq_status;
        if (irq_w1c) begin
            next_irq_status = irq_status & ~avs_writedata[7:0]; // [RULE9]
        end
        next_irq_status = next_irq_status | set_vec;
        next_break_clear_enable = break_clear_enable;
        next_irq_mask = irq_mask;
        if (done && avs_write && avs_address == `RCS_ADDR_BRKCTL) begin
            next_break_clear_enable = avs_writedata[`RCS_BIT_BREAK_CLEAR]; // [RULE9]
        end
        if (done && avs_write && avs_address == `RCS_ADDR_IRQ_MASK) begin
            next_irq_mask = avs_writedata[7:0];
        end
        next_irq = |(irq_status & irq_mask);
    end

    // Power-on is the module reset itself: flag set, all others clear.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cause_status <= `RCS_CAUSE_RESET; // [RULE2]
            irq_status <= `RCS_IRQ_STATUS_RESET;
            irq_mask <= `RCS_IRQ_MASK_RESET;
            break_clear_enable <= break_ctl_init[`RCS_BIT_BREAK_CLEAR];
            irq <= 1'b0;
        end else begin
            cause_status <= next_cause_status;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            break_clear_enable <= next_break_clear_enable;
            irq <= next_irq;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_req_seen;
        req && state == BUS_IDLE;
    endsequence
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    bus_handshake_a: assert property (s_req_seen |=> s_answer) // [RULE1]
        else $error("access not answered after one wait cycle");
    read_clears_a: assert property (rd_cause_clr |=> // [RULE1]
        ((cause_status & $past(avs_readdata[7:0]) & ~$past(set_vec)) == 8'h00))
        else $error("status read did not clear returned flags");
    por_value_a: assert property ($rose(rst_n) |-> cause_status == 8'h80) // [RULE2]
        else $error("power-on value wrong");
    pin_set_a: assert property (src_evt[5] |=> cause_status[`RCS_BIT_PIN]) // [RULE3]
        else $error("pin flag not set");
    watchdog_set_a: assert property (src_evt[4] |=> cause_status[`RCS_BIT_WATCHDOG]) // [RULE4]
        else $error("watchdog flag not set");
    opcode_set_a: assert property (src_evt[3] |=> cause_status[`RCS_BIT_ILLEGAL_INSTR]) // [RULE5]
        else $error("illegal opcode flag not set");
    fetch_only_a: assert property ((src_evt[2] && !in_sync[6] && // [RULE6]
        !cause_status[`RCS_BIT_ILLEGAL_FETCH]) |=>
        !cause_status[`RCS_BIT_ILLEGAL_FETCH])
        else $error("illegal address flag set by data access");
    monitor_set_a: assert property (src_evt[1] |=> cause_status[`RCS_BIT_MONITOR]) // [RULE7]
        else $error("monitor entry flag not set");
    voltage_set_a: assert property (src_evt[0] |=> cause_status[`RCS_BIT_LOW_VOLTAGE]) // [RULE8]
        else $error("low-voltage flag not set");
    enable_write_a: assert property ( // [RULE9]
        (done && avs_write && avs_address == `RCS_ADDR_BRKCTL) |=>
        break_clear_enable == $past(avs_writedata[`RCS_BIT_BREAK_CLEAR]))
        else $error("break-clear enable not written");
    break_hold_a: assert property ( // [RULE10]
        (done && avs_read && avs_address == `RCS_ADDR_CAUSE && in_break && !break_clear_enable)
        |=> cause_status == ($past(cause_status) | $past(set_vec)))
        else $error("flags cleared in break without enable");
    irq_level_a: assert property ((|(irq_status & irq_mask)) |=> irq)
        else $error("interrupt not raised");
    irq_low_a: assert property (!(|(irq_status & irq_mask)) |=> !irq)
        else $error("interrupt raised with nothing pending");

    // ------------------------------------------------------------
    // Flag register invariants
    // ------------------------------------------------------------
    // A cause read is taken from idle; its data must be the flags of the take cycle
    sequence s_cause_taken;
        state == BUS_IDLE && avs_read && avs_address == `RCS_ADDR_CAUSE;
    endsequence
    sequence s_cause_returned;
        !avs_waitrequest && avs_readdata[7:0] == $past(cause_status);
    endsequence

    cause_return_a: assert property (s_cause_taken |=> s_cause_returned) // [RULE1]
        else $error("cause read returned wrong flags");
    // Outside a clearing read the flags only ever gain bits
    flag_hold_a: assert property (!rd_cause_clr |=> // [RULE1]
        cause_status == ($past(cause_status) | $past(set_vec)))
        else $error("cause flags changed without read or event");
    power_flag_a: assert property (!cause_status[`RCS_BIT_POWER_ON] |=> // [RULE2]
        !cause_status[`RCS_BIT_POWER_ON])
        else $error("power-on flag set without power-on reset");
    fetch_set_a: assert property ((src_evt[2] && in_sync[6]) |=> // [RULE6]
        cause_status[`RCS_BIT_ILLEGAL_FETCH])
        else $error("illegal address flag not set by fetch");
    break_clear_a: assert property ( // [RULE9]
        (done && avs_read && avs_address == `RCS_ADDR_CAUSE && in_break && break_clear_enable)
        |=> (cause_status & $past(avs_readdata[7:0]) & ~$past(set_vec)) == 8'h00)
        else $error("flags not cleared in break with enable set");
    enable_hold_a: assert property ( // [RULE9]
        !(done && avs_write && avs_address == `RCS_ADDR_BRKCTL) |=> $stable(break_clear_enable))
        else $error("break-clear enable changed without a write");
    unused_bit_a: assert property (!cause_status[0] && !irq_status[0])
        else $error("unused status bit set");

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    status_set_a: assert property ((|set_vec) |=>
        (irq_status & $past(set_vec)) == $past(set_vec))
        else $error("event did not reach interrupt status");
    status_hold_a: assert property (!irq_w1c |=>
        irq_status == ($past(irq_status) | $past(set_vec)))
        else $error("interrupt status changed without clear or event");
    w1c_clear_a: assert property ( // [RULE9]
        (done && avs_write && avs_address == `RCS_ADDR_IRQ_STATUS &&
        (!in_break || break_clear_enable)) |=>
        (irq_status & $past(avs_writedata[7:0]) & ~$past(set_vec)) == 8'h00)
        else $error("interrupt status not cleared by write");
    w1c_hold_a: assert property ( // [RULE9]
        (done && avs_write && avs_address == `RCS_ADDR_IRQ_STATUS &&
        in_break && !break_clear_enable) |=>
        irq_status == ($past(irq_status) | $past(set_vec)))
        else $error("interrupt status cleared in break without enable");
    mask_write_a: assert property (
        (done && avs_write && avs_address == `RCS_ADDR_IRQ_MASK) |=>
        irq_mask == $past(avs_writedata[7:0]))
        else $error("interrupt mask not written");
    por_regs_a: assert property ($rose(rst_n) |-> (irq_status == `RCS_IRQ_STATUS_RESET &&
        irq_mask == `RCS_IRQ_MASK_RESET && !break_clear_enable))
        else $error("register reset values wrong");

    // ------------------------------------------------------------
    // Bus timing
    // ------------------------------------------------------------
    wait_state_a: assert property (avs_waitrequest == (state == BUS_IDLE))
        else $error("waitrequest out of step with the bus state");
    wait_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    rdata_hold_a: assert property (!(state == BUS_IDLE && avs_read) |=> $stable(avs_readdata))
        else $error("read data changed outside a read");
    rdata_upper_a: assert property (avs_readdata[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
endmodule

//--- verilog/rcs_defs.svh
`ifndef RCS_DEFS_SVH
`define RCS_DEFS_SVH

// Register byte addresses
`define RCS_ADDR_CAUSE 4'h0
`define RCS_ADDR_BRKCTL 4'h4
`define RCS_ADDR_IRQ_STATUS 4'h8
`define RCS_ADDR_IRQ_MASK 4'hC

// Cause flag positions and the break control enable bit
`define RCS_BIT_POWER_ON 7
`define RCS_BIT_PIN 6
`define RCS_BIT_WATCHDOG 5
`define RCS_BIT_ILLEGAL_INSTR 4
`define RCS_BIT_ILLEGAL_FETCH 3
`define RCS_BIT_MONITOR 2
`define RCS_BIT_LOW_VOLTAGE 1
`define RCS_BIT_BREAK_CLEAR 7

// Reset values
`define RCS_CAUSE_RESET 8'h80
`define RCS_BRKCTL_RESET 8'h00
`define RCS_IRQ_STATUS_RESET 8'h80
`define RCS_IRQ_MASK_RESET 8'h00

`endif

//--- verilog/rcs_pkg.sv
package rcs_pkg;
    typedef logic [7:0] rcs_byte_t;
    typedef logic [31:0] rcs_word_t;
    typedef logic [3:0] rcs_addr_t;
    typedef logic [5:0] rcs_src_t;
    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } rcs_bus_state_t;
endpackage

//--- sim/reset_cause_status_regs_tb.sv
`timescale 1ns/10ps
`include "rcs_defs.svh"
module reset_cause_status_regs_tb;
    import rcs_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic fetch_src = 1'b0;
    logic break_src = 1'b0;
    logic avs_waitrequest;
    logic irq;
    rcs_addr_t avs_address = 4'h0;
    rcs_word_t avs_writedata = 32'h0;
    rcs_word_t avs_readdata;
    rcs_src_t cause_src = 6'h00;
    rcs_byte_t q;
    int errors = 0;
    int tests_run = 0;
    // Behavioural picture of cause flags, irq status, mask and break-clear enable
    logic [7:0] mc, mi, mk, mb;
    int s;

    rcs_regs dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .cause_src(cause_src), .fetch_src(fetch_src), .break_src(break_src), .irq(irq));

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic chk(input rcs_byte_t g, input rcs_byte_t e);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Holds the request until waitrequest is sampled low, then lets go
    task automatic bus(input logic wr, input rcs_addr_t a, input rcs_byte_t d);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0 && ++n < 100);
        if (n >= 100) errors++;
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // Cause read: flags clear unless in break with the enable off
    task automatic rc();
        bus(1'b0, `RCS_ADDR_CAUSE, 8'h00);
        chk(q, mc);
        if (!(break_src && !mb[7])) mc = 8'h00;
    endtask

    task automatic fire(input rcs_src_t src, input logic f);
        @(posedge sys_clk);
        cause_src <= src;
        fetch_src <= f;
        repeat (3) @(posedge sys_clk);
        cause_src <= 6'h00;
        repeat (4) @(posedge sys_clk);
        fetch_src <= 1'b0;
        // Illegal-address flag counts only for opcode fetches
        mc = mc | ({src, 1'b0} & (f ? 8'hFF : 8'hF7));
        mi = mi | ({src, 1'b0} & (f ? 8'hFF : 8'hF7));
    endtask

    task automatic do_reset();
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        mc = 8'h80;
        mi = 8'h80;
        mk = 8'h00;
        mb = 8'h00;
    endtask

    task finish_test;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        finish_test;
    end

    initial begin
        void'($urandom(72));
        do_reset();
        rc();
        rc();
        bus(1'b0, 4'h2, 8'h00);
        chk(q, 8'h00);
        for (int i = 0; i < 6; i++) begin
            fire(6'h01 << i, 1'b1);
            rc();
        end
        fire(6'h04, 1'b0);
        rc();
        repeat (6) begin
            s = $urandom;
            fire(s[5:0], s[6]);
            if (s[7]) rc();
        end
        rc();
        fire(6'h20, 1'b0);
        break_src <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rc();
        rc();
        bus(1'b1, `RCS_ADDR_IRQ_STATUS, 8'hFF);
        bus(1'b0, `RCS_ADDR_IRQ_STATUS, 8'h00);
        chk(q, mi);
        bus(1'b1, `RCS_ADDR_BRKCTL, 8'h80);
        mb = 8'h80;
        bus(1'b0, `RCS_ADDR_BRKCTL, 8'h00);
        chk(q, mb);
        rc();
        rc();
        break_src <= 1'b0;
        chk({7'h0, irq}, 8'h00);
        bus(1'b1, `RCS_ADDR_IRQ_MASK, 8'hFF);
        mk = 8'hFF;
        repeat (3) @(posedge sys_clk);
        chk({7'h0, irq}, {7'h0, |(mi & mk)});
        bus(1'b0, `RCS_ADDR_IRQ_MASK, 8'h00);
        chk(q, mk);
        bus(1'b0, `RCS_ADDR_IRQ_STATUS, 8'h00);
        chk(q, mi);
        bus(1'b1, `RCS_ADDR_IRQ_STATUS, mi);
        mi = 8'h00;
        repeat (3) @(posedge sys_clk);
        chk({7'h0, irq}, 8'h00);
        fire(6'h3F, 1'b1);
        do_reset();
        rc();
        finish_test;
    end
endmodule
